/* File: rtcpt_top.sv */
// real-time counter with compare, period and a periodic tick timer
// assumes reference clocks arrive as slow levels on plain inputs and
// software polls the busy flags before rewriting a staged register
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module rtcpt_top #(
  parameter int CNT_W = 16,
  parameter int PRESC_W = 15
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [rtcpt_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rtcpt_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [rtcpt_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_crystal_osc,
  input wire logic i_ext_clk,
  input wire logic i_ultra_low_power_osc,
  input wire logic i_standby,
  input wire logic i_debug_halt,
  output logic o_irq,
  output logic o_cmp_event,
  output logic o_ovf_event,
  output logic [rtcpt_pkg::PIT_EV_N-1:0] o_pit_event
);
  import rtcpt_pkg::*;

  // refuse sizes the register port or setting field cannot carry
  if (CNT_W < 2 || CNT_W > DATA_W) begin : g_bad_cnt
    $error("counter width must be 2 to the data width");
  end
  if (PRESC_W < 1 || PRESC_W > 15) begin : g_bad_presc
    $error("prescaler width must be 1 to 15");
  end

  // clock source edges
  logic xtal_rise;
  logic ext_rise;
  logic ulp_rise;
  logic [4:0] ulp_div;
  logic [4:0] next_ulp_div;
  logic ref_tick;

  // software visible settings
  logic [7:0] ctrl_act;
  logic [7:0] ctrl_stage;
  logic [CNT_W-1:0] cnt_stage;
  logic [CNT_W-1:0] per_act;
  logic [CNT_W-1:0] per_stage;
  logic [CNT_W-1:0] cmp_act;
  logic [CNT_W-1:0] cmp_stage;
  logic [4:0] pit_act;
  logic [4:0] pit_stage;
  logic [BUSY_N-1:0] busy;
  logic [INT_N-1:0] int_en;
  logic run_in_debug_halt;
  logic [1:0] clksel;
  logic [7:0] next_ctrl_act;
  logic [7:0] next_ctrl_stage;
  logic [CNT_W-1:0] next_cnt_stage;
  logic [CNT_W-1:0] next_per_act;
  logic [CNT_W-1:0] next_per_stage;
  logic [CNT_W-1:0] next_cmp_act;
  logic [CNT_W-1:0] next_cmp_stage;
  logic [4:0] next_pit_act;
  logic [4:0] next_pit_stage;
  logic [BUSY_N-1:0] next_busy;
  logic [INT_N-1:0] next_int_en;
  logic next_run_in_debug_halt;
  logic [1:0] next_clksel;

  // counting state
  logic [PRESC_W-1:0] presc_cnt;
  logic [PRESC_W-1:0] presc_mask;
  logic [PRESC_W-1:0] next_presc_cnt;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [PIT_CNT_W-1:0] pit_cnt;
  logic [PIT_CNT_W-1:0] pit_mask;
  logic [PIT_CNT_W-1:0] next_pit_cnt;
  logic [INT_N-1:0] flags;
  logic [INT_N-1:0] next_flags;
  logic [INT_N-1:0] set_flags;
  logic next_cmp_event;
  logic next_ovf_event;
  logic [PIT_EV_N-1:0] next_pit_event;
  logic [DATA_W-1:0] next_rdata;

  // decoded conditions
  logic counter_on;
  logic rtc_run;
  logic pit_run;
  logic count_tick;
  logic rtc_step;
  logic pit_step;
  logic pit_irq_tick;
  logic cmp_hit;
  logic ovf_hit;
  logic cnt_apply;
  logic [3:0] presc_sel;
  logic [3:0] pit_period;

  // one edge detector per reference pin
  rtcpt_edge u_xtal (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_level(i_crystal_osc),
    .o_rise(xtal_rise)
  );
  rtcpt_edge u_ext (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_level(i_ext_clk),
    .o_rise(ext_rise)
  );
  rtcpt_edge u_ulp (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_level(i_ultra_low_power_osc),
    .o_rise(ulp_rise)
  );

  // reference selection, slow oscillator also offered divided by 32
  always_comb begin
    next_ulp_div = ulp_rise ? ulp_div + 5'h01 : ulp_div;
    case (rtcpt_src_t'(clksel))
      SRC_CRYSTAL: ref_tick = xtal_rise;
      SRC_EXT: ref_tick = ext_rise;
      SRC_ULP: ref_tick = ulp_rise;
      SRC_ULP_DIV32: ref_tick = ulp_rise && (ulp_div == ULP_DIV_LAST);
      default: ref_tick = 1'b0;
    endcase
  end

  // run conditions for sleep and debug halt
  always_comb begin
    presc_sel = ctrl_act[CTRL_PRESC_LSB +: 4];
    pit_period = pit_act[PIT_PERIOD_LSB +: 4];
    counter_on = ctrl_act[CTRL_EN_BIT];
    rtc_run = !(i_standby && !ctrl_act[CTRL_STBY_BIT])
      && !(i_debug_halt && !run_in_debug_halt);
    // tick timer ignores sleep entirely, only debug halt stops it
    pit_run = !(i_debug_halt && !run_in_debug_halt);
    for (int i = 0; i < PRESC_W; i++) begin
      presc_mask[i] = (i < int'(presc_sel));
    end
    count_tick = ref_tick && ((presc_cnt & presc_mask) == presc_mask);
    rtc_step = count_tick && counter_on && rtc_run;
    cmp_hit = (cnt == cmp_act);
    ovf_hit = (cnt == per_act);
    cnt_apply = busy[BUSY_CNT] && ref_tick;
    pit_step = ref_tick && pit_act[PIT_EN_BIT] && pit_run;
    for (int i = 0; i < PIT_CNT_W; i++) begin
      pit_mask[i] = (i <= int'(pit_period));
    end
    // period codes 1..14 give 4..32768 reference periods
    pit_irq_tick = pit_step && (pit_period != 4'h0)
      && (pit_period <= 4'he)
      && ((pit_cnt & pit_mask) == pit_mask);
  end

  // register writes; staged values cross on the next reference tick
  always_comb begin
    next_ctrl_act = ctrl_act;
    next_ctrl_stage = ctrl_stage;
    next_cnt_stage = cnt_stage;
    next_per_act = per_act;
    next_per_stage = per_stage;
    next_cmp_act = cmp_act;
    next_cmp_stage = cmp_stage;
    next_pit_act = pit_act;
    next_pit_stage = pit_stage;
    next_busy = busy;
    next_int_en = int_en;
    next_run_in_debug_halt = run_in_debug_halt;
    next_clksel = clksel;
    // land each pending value, then let a fresh write re-arm busy
    if (ref_tick) begin
      if (busy[BUSY_CTRL]) next_ctrl_act = ctrl_stage;
      if (busy[BUSY_PER]) next_per_act = per_stage;
      if (busy[BUSY_CMP]) next_cmp_act = cmp_stage;
      if (busy[BUSY_PIT]) next_pit_act = pit_stage;
      next_busy = '0;
    end
    if (i_wr) begin
      case (i_addr)
        OFS_CTRL: begin
          next_ctrl_stage = i_wdata[7:0];
          next_busy[BUSY_CTRL] = 1'b1;
        end
        OFS_CNT: begin
          next_cnt_stage = i_wdata[CNT_W-1:0];
          next_busy[BUSY_CNT] = 1'b1;
        end
        OFS_PER: begin
          next_per_stage = i_wdata[CNT_W-1:0];
          next_busy[BUSY_PER] = 1'b1;
        end
        OFS_CMP: begin
          next_cmp_stage = i_wdata[CNT_W-1:0];
          next_busy[BUSY_CMP] = 1'b1;
        end
        OFS_PIT_CTRL: begin
          next_pit_stage = i_wdata[4:0];
          next_busy[BUSY_PIT] = 1'b1;
        end
        OFS_INT_EN: next_int_en = i_wdata[INT_N-1:0];
        OFS_DBG: next_run_in_debug_halt = i_wdata[DBG_RUN_BIT];
        OFS_CLKSEL: next_clksel = i_wdata[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ulp_div <= 5'h00;
      ctrl_act <= CTRL_RST;
      ctrl_stage <= CTRL_RST;
      cnt_stage <= '0;
      per_act <= PER_RST[CNT_W-1:0];
      per_stage <= PER_RST[CNT_W-1:0];
      cmp_act <= CMP_RST[CNT_W-1:0];
      cmp_stage <= CMP_RST[CNT_W-1:0];
      pit_act <= PIT_RST;
      pit_stage <= PIT_RST;
      busy <= '0;
      int_en <= '0;
      run_in_debug_halt <= 1'b0;
      clksel <= 2'h0;
    end else begin
      ulp_div <= next_ulp_div;
      ctrl_act <= next_ctrl_act;
      ctrl_stage <= next_ctrl_stage;
      cnt_stage <= next_cnt_stage;
      per_act <= next_per_act;
      per_stage <= next_per_stage;
      cmp_act <= next_cmp_act;
      cmp_stage <= next_cmp_stage;
      pit_act <= next_pit_act;
      pit_stage <= next_pit_stage;
      busy <= next_busy;
      int_en <= next_int_en;
      run_in_debug_halt <= next_run_in_debug_halt;
      clksel <= next_clksel;
    end
  end

  // counter, prescaler, tick timer, flags and events
  always_comb begin
    next_presc_cnt = presc_cnt;
    next_cnt = cnt;
    next_pit_cnt = pit_cnt;
    set_flags = '0;
    next_cmp_event = 1'b0;
    next_ovf_event = 1'b0;
    next_pit_event = '0;
    if (!counter_on) begin
      next_presc_cnt = '0;
    end else if (ref_tick && rtc_run) begin
      next_presc_cnt = presc_cnt + 1'b1;
    end
    if (rtc_step) begin
      // both checks stand alone so equal compare and period both fire
      next_cmp_event = cmp_hit;
      next_ovf_event = ovf_hit;
      set_flags[INT_CMP] = cmp_hit;
      set_flags[INT_OVF] = ovf_hit;
      next_cnt = ovf_hit ? '0 : cnt + 1'b1;
    end
    if (cnt_apply) next_cnt = cnt_stage; // software load wins the tick
    if (!pit_act[PIT_EN_BIT]) begin
      next_pit_cnt = '0;
    end else if (pit_step) begin
      next_pit_cnt = pit_cnt + 1'b1;
      // event k fires every 8192 >> k reference periods
      for (int k = 0; k < PIT_EV_N; k++) begin
        // constant-width mask keeps the select legal for any k
        next_pit_event[k] = &(pit_cnt
          | ~PIT_CNT_W'((1 << (PIT_EV0_BITS - k)) - 1));
      end
    end
    set_flags[INT_PIT] = pit_irq_tick;
    // a flag set in its own clear cycle survives
    next_flags = flags;
    if (i_wr && i_addr == OFS_INT_CLR) begin
      next_flags = flags & ~i_wdata[INT_N-1:0];
    end
    next_flags = next_flags | set_flags;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      presc_cnt <= '0;
      cnt <= '0;
      pit_cnt <= '0;
      flags <= '0;
      o_cmp_event <= 1'b0;
      o_ovf_event <= 1'b0;
      o_pit_event <= '0;
    end else begin
      presc_cnt <= next_presc_cnt;
      cnt <= next_cnt;
      pit_cnt <= next_pit_cnt;
      flags <= next_flags;
      o_cmp_event <= next_cmp_event;
      o_ovf_event <= next_ovf_event;
      o_pit_event <= next_pit_event;
    end
  end

  // level request while any enabled flag is set
  assign o_irq = |(flags & int_en);

  // read data stands only in the cycle after the read strobe;
  // the live count is returned, fine while the system clock is fast
  always_comb begin
    next_rdata = '0;
    if (i_rd) begin
      case (i_addr)
        OFS_CTRL: next_rdata = {8'h00, ctrl_stage};
        OFS_STATUS: next_rdata = DATA_W'({busy[BUSY_CMP:BUSY_CTRL]});
        OFS_INT_EN: next_rdata = DATA_W'(int_en);
        OFS_INT_STAT: next_rdata = DATA_W'(flags);
        OFS_DBG: next_rdata = DATA_W'(run_in_debug_halt);
        OFS_CLKSEL: next_rdata = DATA_W'(clksel);
        OFS_CNT: next_rdata = DATA_W'(cnt);
        OFS_PER: next_rdata = DATA_W'(per_stage);
        OFS_CMP: next_rdata = DATA_W'(cmp_stage);
        OFS_PIT_CTRL: next_rdata = DATA_W'(pit_stage);
        OFS_PIT_STAT: next_rdata = DATA_W'(busy[BUSY_PIT]);
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  property p_step_adds_one;
    rtc_step && !ovf_hit && !cnt_apply |=> cnt == $past(cnt) + 1'b1;
  endproperty
  a_step_adds_one: assert property (p_step_adds_one)
    else $error("counter did not advance by one");

  property p_cmp_flag;
    rtc_step && cmp_hit |=> o_cmp_event && flags[INT_CMP];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag)
    else $error("compare match not flagged");

  property p_ovf_flag;
    rtc_step && ovf_hit |=> o_ovf_event && flags[INT_OVF];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("period overflow not flagged");

  property p_ovf_reload;
    rtc_step && ovf_hit && !cnt_apply |=> cnt == '0;
  endproperty
  a_ovf_reload: assert property (p_ovf_reload)
    else $error("counter not cleared on overflow");

  property p_presc_div;
    rtc_step |-> ((presc_cnt & presc_mask) == presc_mask) && ref_tick;
  endproperty
  a_presc_div: assert property (p_presc_div)
    else $error("counter stepped off a prescaler boundary");

  property p_div32;
    clksel == 2'h3 && ref_tick |-> ulp_rise && ulp_div == 5'h1f;
  endproperty
  a_div32: assert property (p_div32)
    else $error("divided source ticked early");

  property p_pit_four;
    pit_step && pit_period == 4'h1 && pit_cnt[1:0] == 2'h3
      |=> flags[INT_PIT];
  endproperty
  a_pit_four: assert property (p_pit_four)
    else $error("tick interrupt missed at four periods");

  property p_pit_ev64;
    pit_step && pit_cnt[5:0] == 6'h3f |=> o_pit_event[7];
  endproperty
  a_pit_ev64: assert property (p_pit_ev64)
    else $error("64 period event missed");

  property p_halt_stops;
    i_debug_halt && !run_in_debug_halt && !cnt_apply |=> $stable(cnt);
  endproperty
  a_halt_stops: assert property (p_halt_stops)
    else $error("counter moved during debug halt");

  property p_irq_level;
    flags[INT_OVF] && int_en[INT_OVF] |-> o_irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt dropped with enabled flag set");

  property p_standby_stop;
    i_standby && !ctrl_act[CTRL_STBY_BIT] |-> !rtc_step;
  endproperty
  a_standby_stop: assert property (p_standby_stop)
    else $error("counter ran in standby without run bit");

  property p_busy_set;
    i_wr && i_addr == OFS_CTRL |=> busy[BUSY_CTRL];
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("control busy not raised by write");

  property p_busy_hold;
    busy[BUSY_CTRL] && !ref_tick |=> busy[BUSY_CTRL];
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("control busy dropped before landing");

  property p_ctrl_land;
    busy[BUSY_CTRL] && ref_tick |=> ctrl_act == $past(ctrl_stage);
  endproperty
  a_ctrl_land: assert property (p_ctrl_land)
    else $error("staged control did not land on tick");

endmodule

/* File: rtcpt_pkg.sv */
// constants shared by the real-time counter with periodic tick
// assumes a 16-bit register port and one 25 MHz system clock
package rtcpt_pkg;

  // system clock rate
  localparam int REF_CLK_HZ = 25000000;

  // register port widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_INT_EN = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 5'h03;
  localparam logic [ADDR_W-1:0] OFS_INT_CLR = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_DBG = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_CLKSEL = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_CNT = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_PER = 5'h0a;
  localparam logic [ADDR_W-1:0] OFS_CMP = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_PIT_CTRL = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_PIT_STAT = 5'h11;

  // control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PRESC_LSB = 1;
  localparam int CTRL_STBY_BIT = 7;
  localparam int PIT_EN_BIT = 0;
  localparam int PIT_PERIOD_LSB = 1;
  localparam int DBG_RUN_BIT = 0;

  // busy flag positions; bits 0 to 3 read in the status register, the tick timer one in its own
  localparam int BUSY_CTRL = 0;
  localparam int BUSY_CNT = 1;
  localparam int BUSY_PER = 2;
  localparam int BUSY_CMP = 3;
  localparam int BUSY_PIT = 4;
  localparam int BUSY_N = 5;

  // interrupt bit positions
  localparam int INT_OVF = 0;
  localparam int INT_CMP = 1;
  localparam int INT_PIT = 2;
  localparam int INT_N = 3;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] PIT_RST = 5'h00;
  localparam logic [15:0] PER_RST = 16'hffff;
  localparam logic [15:0] CMP_RST = 16'h0000;

  // reference divide for the slow oscillator option
  localparam logic [4:0] ULP_DIV_LAST = 5'h1f;

  // periodic tick events
  localparam int PIT_EV_N = 8;
  localparam int PIT_EV0_BITS = 13;
  localparam int PIT_CNT_W = 15;

  // reference clock sources
  typedef enum logic [1:0] {
    SRC_CRYSTAL = 2'b00,
    SRC_EXT = 2'b01,
    SRC_ULP = 2'b10,
    SRC_ULP_DIV32 = 2'b11
  } rtcpt_src_t;

endpackage

/* File: rtcpt_edge.sv */
// two-stage synchroniser and rising edge detector for a slow clock pin
// assumes the pin toggles far slower than the system clock
`timescale 1ns/1ps
module rtcpt_edge (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_level,
  output logic o_rise
);

  logic meta;
  logic stable;
  logic last;
  logic next_meta;
  logic next_stable;
  logic next_last;

  // only the second stage reads the first
  always_comb begin
    next_meta = i_level;
    next_stable = meta;
    next_last = stable;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      meta <= 1'b0;
      stable <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      last <= next_last;
    end
  end

  assign o_rise = stable & ~last;

endmodule

/* File: rtcpt_osc_model.sv */
// slow reference oscillators that feed the counter block
// assumes one system clock; the external source may be stopped
`timescale 1ns/1ps
module rtcpt_osc_model #(
  parameter int XTAL_HALF = 2,
  parameter int EXT_HALF = 3,
  parameter int ULP_HALF = 5
) (
  input wire logic i_clk,
  input wire logic i_ext_run,
  output logic o_crystal_osc = 1'b0,
  output logic o_ext_clk = 1'b0,
  output logic o_ultra_low_power_osc = 1'b0
);
  int xc = 0;
  int ec = 0;
  int uc = 0;
  // half periods of two or more cycles keep the bus clock 4x faster
  always @(posedge i_clk) begin
    xc <= (xc == XTAL_HALF - 1) ? 0 : xc + 1;
    uc <= (uc == ULP_HALF - 1) ? 0 : uc + 1;
    if (xc == XTAL_HALF - 1) o_crystal_osc <= !o_crystal_osc;
    if (uc == ULP_HALF - 1) o_ultra_low_power_osc <= !o_ultra_low_power_osc;
    // a stopped external clock stands still at its last level
    if (i_ext_run) begin
      ec <= (ec == EXT_HALF - 1) ? 0 : ec + 1;
      if (ec == EXT_HALF - 1) o_ext_clk <= !o_ext_clk;
    end
  end
endmodule

/* File: tb_top.sv */
// self-checking bench for the real-time counter with periodic tick
// assumes crystal period 4, external 6, slow osc 10 system cycles
`timescale 1ns/1ps
module tb_top;
  import rtcpt_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [ADDR_W-1:0] i_addr = 5'h00;
  logic [DATA_W-1:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_standby = 1'b0;
  logic i_debug_halt = 1'b0;
  logic ext_run = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  logic xtal, ext, ulp, o_irq, o_cmp_event, o_ovf_event;
  logic [PIT_EV_N-1:0] o_pit_event;
  logic [15:0] v;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0, t1, p;

  rtcpt_osc_model osc (.i_clk(i_ref_clk), .i_ext_run(ext_run),
    .o_crystal_osc(xtal), .o_ext_clk(ext), .o_ultra_low_power_osc(ulp));
  rtcpt_top uut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_crystal_osc(xtal), .i_ext_clk(ext), .i_ultra_low_power_osc(ulp),
    .i_standby(i_standby), .i_debug_halt(i_debug_halt), .o_irq(o_irq),
    .o_cmp_event(o_cmp_event), .o_ovf_event(o_ovf_event),
    .o_pit_event(o_pit_event));

  always #20 i_ref_clk = ~i_ref_clk;
  // cycle stamp for intervals, and a ceiling against hangs
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt = error_cnt + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // single-cycle bus strobes, changed just after the edge
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  // poll a busy register until clear, bounded
  task automatic settle(input logic [4:0] a);
    logic [15:0] s;
    for (int i = 0; i < 1000; i++) begin
      rd(a, s);
      if (s === 16'h0000) break;
    end
    chk(s, 16'h0000);
  endtask

  function automatic logic sel(input int w);
    if (w >= 10) return o_pit_event[w-10];
    if (w == 1) return o_cmp_event;
    if (w == 2) return o_irq;
    return o_ovf_event;
  endfunction

  // stamp of the next cycle the chosen output is high, -1 if none
  task automatic wait_ev(input int w, input int lim, output int t);
    t = -1;
    for (int i = 0; i < lim && t < 0; i++) begin
      @(posedge i_ref_clk);
      #1;
      if (sel(w) === 1'b1) t = cyc;
    end
  endtask

  task automatic period(input int w, input int lim, output int n);
    int a, b;
    wait_ev(w, lim, a);
    wait_ev(w, lim, b);
    n = (a < 0 || b < 0) ? -1 : b - a;
  endtask

  task automatic t_reset();
    rd(OFS_CTRL, v);
    chk(v, 16'h0000);
    rd(OFS_STATUS, v);
    chk(v, 16'h0000);
    rd(OFS_PER, v);
    chk(v, 16'hffff);
    rd(OFS_CMP, v);
    chk(v, 16'h0000);
    rd(OFS_CNT, v);
    chk(v, 16'h0000);
    rd(5'h1f, v);
    chk(v, 16'h0000);
  endtask

  // staged writes wait on a stopped source, then land
  task automatic t_busy();
    wr(OFS_CLKSEL, 16'h0001);
    wr(OFS_PER, 16'h0005);
    rd(OFS_STATUS, v);
    chk(v, 16'h0004);
    wr(OFS_CMP, 16'h0002);
    rd(OFS_STATUS, v);
    chk(v, 16'h000c);
    ext_run <= 1'b1;
    settle(OFS_STATUS);
    rd(OFS_PER, v);
    chk(v, 16'h0005);
  endtask

  task automatic t_count();
    wr(OFS_INT_EN, 16'h0003);
    wr(OFS_CTRL, 16'h0001);
    settle(OFS_STATUS);
    wait_ev(0, 200, t0);
    wait_ev(1, 200, t1);
    chk(16'(t1 - t0), 16'h0012);
    wait_ev(0, 200, t0);
    chk(16'(t0 - t1), 16'h0012);
    rd(OFS_CNT, v);
    chk(16'(v <= 16'h0005), 16'h0001);
    chk(16'(o_irq), 16'h0001);
    wr(OFS_CTRL, 16'h0000);
    settle(OFS_STATUS);
    rd(OFS_INT_STAT, v);
    chk(v, 16'h0003);
    wr(OFS_INT_CLR, 16'h0001);
    rd(OFS_INT_STAT, v);
    chk(v, 16'h0002);
    chk(16'(o_irq), 16'h0001);
    wr(OFS_INT_EN, 16'h0001);
    #1; // enable lands in this edge's update, look after it
    chk(16'(o_irq), 16'h0000);
    wr(OFS_INT_CLR, 16'h0002);
    // equal compare and period flag together
    wr(OFS_PER, 16'h0003);
    wr(OFS_CMP, 16'h0003);
    // count may sit above the new period, restart it from zero
    wr(OFS_CNT, 16'h0000);
    wr(OFS_CTRL, 16'h0001);
    settle(OFS_STATUS);
    wait_ev(0, 200, t0);
    chk(16'(o_cmp_event), 16'h0001);
  endtask

  // each source and a prescale step, two ticks per overflow
  task automatic t_src();
    logic [1:0] s [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    int pr [5] = '{0, 0, 0, 0, 2};
    int ex [5] = '{8, 12, 20, 640, 32};
    wr(OFS_PER, 16'h0001);
    wr(OFS_CNT, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CLKSEL, {14'h0000, s[i]});
      wr(OFS_CTRL, 16'((pr[i] << 1) | 1));
      settle(OFS_STATUS);
      period(0, 1500, p);
      chk(16'(p), 16'(ex[i]));
    end
  endtask

  task automatic t_sleep();
    wr(OFS_CTRL, 16'h0001);
    settle(OFS_STATUS);
    @(posedge i_ref_clk);
    i_debug_halt <= 1'b1;
    repeat (10) @(posedge i_ref_clk);
    wait_ev(0, 100, t0);
    chk(16'(t0), 16'hffff);
    wr(OFS_DBG, 16'h0001);
    period(0, 100, p);
    chk(16'(p), 16'h0008);
    wr(OFS_DBG, 16'h0000);
    i_debug_halt <= 1'b0;
    wr(OFS_PIT_CTRL, 16'h0003);
    settle(OFS_PIT_STAT);
    @(posedge i_ref_clk);
    i_standby <= 1'b1;
    repeat (10) @(posedge i_ref_clk);
    wait_ev(0, 100, t0);
    chk(16'(t0), 16'hffff);
    period(17, 800, p);
    chk(16'(p), 16'h0100);
    wr(OFS_CTRL, 16'h0081);
    settle(OFS_STATUS);
    period(0, 100, p);
    chk(16'(p), 16'h0008);
    @(posedge i_ref_clk);
    i_standby <= 1'b0;
  endtask

  // tick timer alone, counter stopped
  task automatic t_pit();
    wr(OFS_CTRL, 16'h0000);
    settle(OFS_STATUS);
    wr(OFS_INT_EN, 16'h0004);
    for (int n = 1; n <= 2; n++) begin
      wr(OFS_PIT_CTRL, 16'((n << 1) | 1));
      settle(OFS_PIT_STAT);
      // first request may meet its clear, so time from the second
      wr(OFS_INT_CLR, 16'h0007);
      wait_ev(2, 200, t0);
      wr(OFS_INT_CLR, 16'h0004);
      wait_ev(2, 200, t0);
      wr(OFS_INT_CLR, 16'h0004);
      wait_ev(2, 200, t1);
      chk(16'(t1 - t0), 16'((1 << (n + 1)) * 4));
    end
    for (int k = 7; k >= 4; k--) begin
      period(10 + k, 5000, p);
      chk(16'(p), 16'((8192 >> k) * 4));
    end
  endtask

  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    t_reset();
    t_busy();
    t_count();
    t_src();
    t_sleep();
    t_pit();
    test_done();
  end
endmodule
